// File: ssr_ctl_model.sv
// Controller model driving the serial pins of the block
`timescale 1ns/1ps
module ssr_ctl_model (
    input  wire logic mclk,
    output logic      si,
    output logic      sel_n,
    output logic      rw,
    output logic      shc,
    output logic      stc
);
    initial {si, sel_n, rw, shc, stc} = 5'h08;
    // Each level stands four cycles, off the sampling edge
    task automatic hold();
        repeat (4) @(negedge mclk);
    endtask
    // Select moves only while both clocks rest low
    task automatic sel(input logic v);
        sel_n = v;
        hold();
    endtask
    // One shift pulse; data is scrambled once its hold has run out
    task automatic pulse(input logic b);
        si = b;
        shc = 1'b1;
        hold();
        shc = 1'b0;
        hold();
        si = ~b;
    endtask
    // Store pulse, optionally wrapping a shift pulse for a load
    task automatic xfer(input logic r, input logic ld);
        rw = r;
        hold();
        stc = 1'b1;
        hold();
        if (ld) pulse(1'b0);
        stc = 1'b0;
        hold();
        rw = 1'b0;
        hold();
    endtask
endmodule

// File: ssr_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`include "ssr_params.svh"

module ssr_fifo #(
    parameter int WIDTH = `SSR_WIDTH,
    parameter int DEPTH = `SSR_FIFO_DEPTH,
    parameter int AW    = `SSR_FIFO_AW
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      count_r;
    wire              push;
    wire              pop;

    ////////////////////////////////////////////////////////////////////
    // Handshake decode
    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rptr_r];

    // Storage, written by index
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wptr_r] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge mclk) begin
        if (rst) begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            count_r <= '0;
        end else begin
            wptr_r  <= push ? wptr_r + 1'b1 : wptr_r;
            rptr_r  <= pop ? rptr_r + 1'b1 : rptr_r;
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// File: ssr_params.svh
// Constants for the serial shift and storage register block
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

`define SSR_WIDTH      16
`define SSR_TOP_BIT    15
`define SSR_FIFO_DEPTH 16
`define SSR_FIFO_AW    4
`define SSR_PIN_INIT   5'h02

`endif

// File: ssr_pkg.sv
// Types for the serial shift and storage register block
`include "ssr_params.svh"

package ssr_pkg;
    typedef logic [`SSR_WIDTH-1:0] ssr_word_t;
    typedef enum logic [1:0] {
        SSR_HOLD,
        SSR_SHIFT,
        SSR_LOAD
    } ssr_mode_t;
endpackage

// File: ssr_top.sv
// Serial shift register with storage register and word FIFO
//
// What this block does
// - 16-bit shift register, mode from select, read/write and store level
// - Shift register changes only on falling shift clock with select low
// - Shift right: serial in to stage 0, stage 15 to serial out
// - Select low, read/write high, store high: load from storage
// - Storage holds while select or read/write is high
// - Rising store clock with select and read/write low copies shifter
// - Select high blocks both shifting and loading
// - Storage word shown on parallel outputs; serial pins allow chaining
`timescale 1ns/1ps
`include "ssr_params.svh"

module ssr_top (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  first_stage_input,
    input  wire logic                  select_n,
    input  wire logic                  read_write,
    input  wire logic                  shift_clock_in,
    input  wire logic                  store_clock_in,
    output logic                       top_stage_bit,
    output logic      [`SSR_WIDTH-1:0] parallel_word_out,
    output logic                       word_valid,
    input  wire logic                  word_ready,
    output logic      [`SSR_WIDTH-1:0] word_data,
    output logic                       word_overflow
);
    ////////////////////////////////////////////////////////////////////
    // Pin bundle indices and synchroniser rest levels
    localparam int N_PIN  = 5;
    localparam int PIN_SD = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_RW = 2;
    localparam int PIN_SH = 3;
    localparam int PIN_ST = 4;
    localparam logic [N_PIN-1:0] PIN_INIT = `SSR_PIN_INIT;

    // Edge test on two successive synchronised levels
    function automatic logic edge_seen(
        input logic prev,
        input logic now,
        input logic rising
    );
        return rising ? (~prev & now) : (prev & ~now);
    endfunction

    // Next value of one shifter stage for the decoded mode
    function automatic logic stage_next(
        input ssr_pkg::ssr_mode_t m,
        input logic               fall,
        input logic               cur,
        input logic               below,
        input logic               stored
    );
        logic nxt;
        nxt = cur;
        if (fall) begin
            unique case (m)
                ssr_pkg::SSR_HOLD:  nxt = cur;
                ssr_pkg::SSR_SHIFT: nxt = below;
                ssr_pkg::SSR_LOAD:  nxt = stored;
                default:            nxt = cur;
            endcase
        end
        return nxt;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops each
    // The pins are asynchronous to mclk; every edge is therefore
    // seen two clocks late and acted on at the third, and each pin level must span at least one
    // rising mclk edge for the block to see it at all.
    wire  [N_PIN-1:0] pin_raw;
    wire  [N_PIN-1:0] pin_lvl;
    logic             sh_prev_r;
    logic             st_prev_r;

    // Gather the asynchronous pins into one bundle
    assign pin_raw[PIN_SD] = first_stage_input;
    assign pin_raw[PIN_CS] = select_n;
    assign pin_raw[PIN_RW] = read_write;
    assign pin_raw[PIN_SH] = shift_clock_in;
    assign pin_raw[PIN_ST] = store_clock_in;

    genvar gp;
    generate
        for (gp = 0; gp < N_PIN; gp++) begin : g_sync
            logic meta_r;
            logic safe_r;

            // Only the second flop feeds any logic
            always_ff @(posedge mclk) begin
                if (rst) begin
                    meta_r <= PIN_INIT[gp];
                    safe_r <= PIN_INIT[gp];
                end else begin
                    meta_r <= pin_raw[gp];
                    safe_r <= meta_r;
                end
            end

            assign pin_lvl[gp] = safe_r;
        end
    endgenerate

    // Previous clock levels for edge detection, resting low
    always_ff @(posedge mclk) begin
        if (rst) begin
            sh_prev_r <= 1'b0;
            st_prev_r <= 1'b0;
        end else begin
            sh_prev_r <= pin_lvl[PIN_SH];
            st_prev_r <= pin_lvl[PIN_ST];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Edge and mode decode
    wire sel     = ~pin_lvl[PIN_CS];
    wire rw      = pin_lvl[PIN_RW];
    wire st_lvl  = pin_lvl[PIN_ST];
    wire sd_lvl  = pin_lvl[PIN_SD];
    wire sh_fall = edge_seen(sh_prev_r, pin_lvl[PIN_SH], 1'b0);
    wire st_rise = edge_seen(st_prev_r, pin_lvl[PIN_ST], 1'b1);

    // Store clock level picks load over shift at the shift edge
    ssr_pkg::ssr_mode_t mode;
    assign mode = !sel ? ssr_pkg::SSR_HOLD :
                  (rw && st_lvl) ? ssr_pkg::SSR_LOAD :
                  ssr_pkg::SSR_SHIFT;

    // Storage moves only on a rising store edge, select and write low
    wire store_go = sel && !rw && st_rise;

    ////////////////////////////////////////////////////////////////////
    // Shift register and storage register, no reset on data
    // Data flops carry no reset on purpose: a reset would invent a
    // power-up word that the pins never wrote.
    ssr_pkg::ssr_word_t shift_r;
    ssr_pkg::ssr_word_t shift_nxt;
    ssr_pkg::ssr_word_t store_r;
    ssr_pkg::ssr_word_t below_w;

    // What each stage takes on a shift: its lower neighbour
    assign below_w = {shift_r[`SSR_TOP_BIT-1:0], sd_lvl};

    genvar gs;
    generate
        for (gs = 0; gs < `SSR_WIDTH; gs++) begin : g_stage
            logic keep_r;

            // One stage: hold, shift or load, only on a shift edge
            assign shift_nxt[gs] = stage_next(mode, sh_fall, shift_r[gs],
                                              below_w[gs], store_r[gs]);

            // Storage bit captures its stage on a qualified store edge
            always_ff @(posedge mclk) begin
                if (store_go) begin
                    keep_r <= shift_r[gs];
                end
            end

            assign store_r[gs] = keep_r;
        end
    endgenerate

    // Contents undefined until written
    always_ff @(posedge mclk) begin
        shift_r <= shift_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs: serial tail and parallel word from flops
    assign top_stage_bit     = shift_r[`SSR_TOP_BIT];
    assign parallel_word_out = store_r;

    ////////////////////////////////////////////////////////////////////
    // Stored words are queued for a downstream consumer; one stored while the FIFO is full is dropped and sets word_overflow
    logic store_go_r;
    logic fifo_in_ready;
    logic word_overflow_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            store_go_r      <= 1'b0;
            word_overflow_r <= 1'b0;
        end else begin
            store_go_r      <= store_go;
            word_overflow_r <= word_overflow_r |
                               (store_go_r & ~fifo_in_ready);
        end
    end

    assign word_overflow = word_overflow_r;

    ssr_fifo #(
        .WIDTH (`SSR_WIDTH),
        .DEPTH (`SSR_FIFO_DEPTH),
        .AW    (`SSR_FIFO_AW)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (store_go_r),
        .in_ready  (fifo_in_ready),
        .in_data   (store_r),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_data)
    );
endmodule

// File: ssr_top_sva.sv
// Port checker for the shift and storage register block
`timescale 1ns/1ps
`include "ssr_params.svh"
module ssr_top_chk (
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  first_stage_input,
    input wire logic                  select_n,
    input wire logic                  read_write,
    input wire logic                  shift_clock_in,
    input wire logic                  store_clock_in,
    input wire logic                  top_stage_bit,
    input wire logic [`SSR_WIDTH-1:0] parallel_word_out,
    input wire logic                  word_valid,
    input wire logic                  word_ready,
    input wire logic [`SSR_WIDTH-1:0] word_data,
    input wire logic                  word_overflow
);
    logic primed_r;
    // Armed once a stored word shows both registers written
    always_ff @(posedge mclk) begin
        if (rst) primed_r <= 1'b0;
        else if (word_valid) primed_r <= 1'b1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence desel_s; (select_n && primed_r) [*8]; endsequence
    sequence st_rise_s;
        $rose(store_clock_in) && !select_n && !read_write;
    endsequence
    chk_shift_hold: assert property (desel_s |=> $stable(top_stage_bit))
        else $error("top stage moved while deselected");
    chk_store_hold: assert property (((select_n || read_write) && primed_r)
        [*8] |=> $stable(parallel_word_out))
        else $error("storage moved while held");
    chk_store_word: assert property (st_rise_s |-> ##[4:8] word_valid)
        else $error("stored word not queued");
    chk_word_match: assert property ($rose(word_valid) |->
        word_data == parallel_word_out)
        else $error("queued word differs from storage");
    chk_shift_time: assert property ($changed(top_stage_bit) && primed_r
        |-> $past(shift_clock_in, 6) && !$past(shift_clock_in, 3))
        else $error("top stage moved without falling shift clock");
    chk_store_time: assert property ($changed(parallel_word_out) && primed_r
        |-> $past(store_clock_in, 3) && !$past(store_clock_in, 6)
        && !$past(read_write, 3) && !$past(select_n, 3))
        else $error("storage moved without a qualified store edge");
    chk_ovf_sticky: assert property (word_overflow |=> word_overflow)
        else $error("overflow flag cleared without reset");
    chk_word_stand: assert property (word_valid && !word_ready |=>
        word_valid && $stable(word_data))
        else $error("unpopped word changed");
endmodule
bind ssr_top ssr_top_chk i_chk (.mclk(mclk), .rst(rst),
    .first_stage_input(first_stage_input), .select_n(select_n),
    .read_write(read_write), .shift_clock_in(shift_clock_in),
    .store_clock_in(store_clock_in), .top_stage_bit(top_stage_bit),
    .parallel_word_out(parallel_word_out), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data),
    .word_overflow(word_overflow));

// File: ssr_top_tb.sv
// Self-checking bench for the shift and storage register block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module ssr_top_tb;
    logic              mclk = 1'b0, rst = 1'b1, word_ready = 1'b0;
    logic              si, sel_n, rw, shc, stc, top, vld, ovf;
    ssr_pkg::ssr_word_t par, wdat, q, s, w;
    ssr_pkg::ssr_word_t exp_q[$];
    int                n_mismatch = 0, n_compared = 0, cyc = 0;
    always #2 mclk = ~mclk;
    ssr_top i_dut (.mclk(mclk), .rst(rst), .first_stage_input(si),
        .select_n(sel_n), .read_write(rw), .shift_clock_in(shc),
        .store_clock_in(stc), .top_stage_bit(top),
        .parallel_word_out(par), .word_valid(vld), .word_ready(word_ready),
        .word_data(wdat), .word_overflow(ovf));
    ssr_ctl_model i_ctl (.mclk(mclk), .si(si), .sel_n(sel_n), .rw(rw),
        .shc(shc), .stc(stc));
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Shift one bit through the model and the design
    task automatic shift(input logic b);
        i_ctl.pulse(b);
        q = {q[14:0], b};
        `CHK("top", q[15], top)
    endtask
    // Cut a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'h35d39f30));
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        i_ctl.sel(1'b0);
        // Eighteen words with the consumer stalled: two are dropped
        for (int k = 0; k < 18; k++) begin
            w = 16'($urandom);
            for (int b = 15; b >= 0; b--) shift(w[b]);
            i_ctl.xfer(1'b0, 1'b0);
            s = q;
            if (exp_q.size() < 16) exp_q.push_back(s);
            `CHK("par", s, par)
        end
        `CHK("ovf", 1'b1, ovf)
        // Drain with a randomly stalling consumer
        while (exp_q.size() > 0) begin
            @(negedge mclk);
            word_ready = 1'($urandom);
            if (word_ready && vld) begin
                w = exp_q.pop_front();
                `CHK("word", w, wdat)
            end
        end
        @(negedge mclk);
        word_ready = 1'b0;
        `CHK("vld", 1'b0, vld)
        shift(~q[15]);
        // Deselected: both clocks pulse, nothing moves
        i_ctl.sel(1'b1);
        i_ctl.pulse(~q[14]);
        i_ctl.xfer(1'b0, 1'b0);
        `CHK("top", q[15], top)
        `CHK("par", s, par)
        i_ctl.sel(1'b0);
        i_ctl.xfer(1'b1, 1'b0);
        `CHK("par", s, par)
        // Recirculate storage into the shifter
        i_ctl.xfer(1'b1, 1'b1);
        q = s;
        `CHK("top", q[15], top)
        shift(1'b1);
        close_out();
    end
endmodule
